/* File: rtl/cmp_mask_filter_ctrl.sv */
// Purpose: Comparator blanking, output filter and reference control, AHB-Lite slave
// Assumes: Single word transfers; all inputs synchronous to hclk
// Notes: Zero wait states; unmapped addresses read zero, writes ignored
// Function
// R1: Mask A selector routes one of six PWM outputs, codes 0000 to 0101.
// R2: Software must not write reserved mask source codes 0110 to 1111.
// R3: AND true-A enable at bit 1 connects mask A to the AND gate.
// R4: AND inverted-A enable at bit 0 feeds inverted mask A into AND.
// R5: AND inverted-B enable at bit 2 feeds inverted mask B into AND.
// R6: Filter clock source field selects Fcy, Fosc, PWM event, timer 2 or 3.
// R7: Filter divide field divides selected clock by two to the field value.
// R8: Band gap field: 11 external pin, 10 nominal band gap, 0x reserved.
// R9: Reference output enable drives the pin, overriding pin direction control.
// R10: Step 0 to 15 sets level; range set gives step/24 of source.
// R11: Mask B and C selectors use the mask A encoding and reserved codes.
// R12: Polarity bit set blocks active-low signal during mask; clear blocks active-high.
`timescale 1ns/1ps
module cmp_mask_filter_ctrl
  import cmp_mask_pkg::*;
#(
  parameter int FILTER_DEPTH = 3
)
(
  input wire logic hclk, // Bus clock, 50 MHz
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [7:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write not read
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready in
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  input wire logic [PWM_OUTS-1:0] pwm_out, // PWM outputs for masking
  input wire fclk_src_s fclk_src, // Filter clock candidates
  input wire logic cmp_raw, // Raw comparator output
  input wire logic pin_direction_ctrl, // Pin direction, 1 is input
  output logic cmp_out, // Blanked and filtered output
  output logic mask_active_out, // Current blanking mask
  output vref_ctrl_s vref_ctrl, // Reference control to analog
  output logic bg_reserved, // Reserved band gap code written
  output logic ref_pin_oe // Reference pin drive enable
);

  // ==========================================================
  // Register state
  logic [15:0] mask_src_reg;
  logic [15:0] mask_gate_reg;
  logic [15:0] filter_reg;
  logic [15:0] vref_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] rd_next;
  logic addr_ok;
  logic wr_take;
  logic rd_take;

  // Bus phase decode
  assign addr_ok = hsel & hready & (htrans == HTRANS_NONSEQ) & (hsize == HSIZE_WORD);
  assign wr_take = addr_ok & hwrite;
  assign rd_take = addr_ok & ~hwrite;

  // ==========================================================
  // Datapath signals
  logic mask_w;
  logic tick;
  logic blanked;
  logic [FILTER_DEPTH-1:0] hist_reg;
  logic filt_reg;
  logic cmp_out_reg;
  logic mask_reg;
  logic oe_reg;
  logic bg_res_reg;
  vref_ctrl_s vref_reg_out;
  logic [15:0] status_w;

  // Read multiplexer
  assign status_w = {13'h0000, filt_reg, mask_reg, cmp_out_reg};
  always_comb
  begin
    case (haddr)
      OFS_MASK_SRC: rd_next = {16'h0000, mask_src_reg};
      OFS_MASK_GATE: rd_next = {16'h0000, mask_gate_reg};
      OFS_FILTER: rd_next = {16'h0000, filter_reg};
      OFS_VREF: rd_next = {16'h0000, vref_reg};
      OFS_STATUS: rd_next = {16'h0000, status_w};
      default: rd_next = 32'h00000000;
    endcase
  end

  // Address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
    end
    else
    begin
      wr_pend_reg <= wr_take;
      if (wr_take)
        wr_addr_reg <= haddr;
      if (rd_take)
        hrdata_reg <= rd_next;
    end
  end

  // Register writes in the data phase; software keeps codes defined
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mask_src_reg <= REG_RESET;
      mask_gate_reg <= REG_RESET;
      filter_reg <= REG_RESET;
      vref_reg <= REG_RESET;
    end
    else if (wr_pend_reg)
    begin
      case (wr_addr_reg)
        OFS_MASK_SRC: mask_src_reg <= hwdata[15:0] & MASK_SRC_WMASK; // R2
        OFS_MASK_GATE: mask_gate_reg <= hwdata[15:0] & MASK_GATE_WMASK;
        OFS_FILTER: filter_reg <= hwdata[15:0] & FILTER_WMASK;
        OFS_VREF: vref_reg <= hwdata[15:0] & VREF_WMASK;
        default: ;
      endcase
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ==========================================================
  // Mask selection and gating
  mask_gate u_mask_gate (
    .pwm_out(pwm_out),
    .src_sel(mask_src_reg[11:0]),
    .gate_ctrl(mask_gate_reg),
    .mask_active(mask_w)
  );

  // Blanking: polarity picks which comparator level is held off
  assign blanked = mask_gate_reg[GATE_POLARITY]
    ? (cmp_raw | mask_w) // R12
    : (cmp_raw & ~mask_w); // R12

  // ==========================================================
  // Filter sample clock
  filter_clk_gen #(
    .DIV_W(7)
  ) u_filter_clk (
    .hclk(hclk),
    .hresetn(hresetn),
    .src(fclk_src),
    .src_sel(filter_reg[FLT_SRC_LSB +: 3]),
    .div_sel(filter_reg[FLT_DIV_LSB +: 3]),
    .tick(tick)
  );

  // Filter: output changes when the new sample and the newest FILTER_DEPTH-1 history samples agree
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hist_reg <= '0;
      filt_reg <= 1'b0;
    end
    else if (tick)
    begin
      hist_reg <= {hist_reg[FILTER_DEPTH-2:0], blanked};
      if (&{hist_reg[FILTER_DEPTH-2:0], blanked})
        filt_reg <= 1'b1;
      else if (~|{hist_reg[FILTER_DEPTH-2:0], blanked})
        filt_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Reference control decode
  always_comb
  begin
    vref_reg_out.enable = vref_reg[VREF_EN];
    vref_reg_out.ext_select = vref_reg[VREF_SEL];
    vref_reg_out.bg_source = vref_reg[VREF_BG_LSB +: 2]; // R8
    vref_reg_out.range = vref_reg[VREF_RANGE]; // R10
    vref_reg_out.step = vref_reg[VREF_STEP_LSB +: 4]; // R10
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmp_out_reg <= 1'b0;
      mask_reg <= 1'b0;
      oe_reg <= 1'b0;
      bg_res_reg <= 1'b0;
      vref_ctrl <= '0;
    end
    else
    begin
      cmp_out_reg <= filter_reg[FLT_ON] ? filt_reg : blanked;
      mask_reg <= mask_w;
      // Output enable overrides pin direction
      oe_reg <= vref_reg[VREF_OUT_EN] | ~pin_direction_ctrl; // R9
      bg_res_reg <= ~vref_reg[VREF_BG_LSB + 1]; // R8
      vref_ctrl <= vref_reg_out;
    end
  end

  assign cmp_out = cmp_out_reg;
  assign mask_active_out = mask_reg;
  assign ref_pin_oe = oe_reg;
  assign bg_reserved = bg_res_reg;

endmodule

/* File: rtl/cmp_mask_pkg.sv */
// Purpose: Shared constants and types for the comparator mask/filter control block
// Assumes: 32-bit AHB-Lite data, registers one aligned word each
// Notes: Register offsets are byte addresses
package cmp_mask_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] OFS_MASK_SRC = 8'h00;
  localparam logic [7:0] OFS_MASK_GATE = 8'h04;
  localparam logic [7:0] OFS_FILTER = 8'h08;
  localparam logic [7:0] OFS_VREF = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // Writable bit masks; unimplemented bits read zero
  localparam logic [15:0] MASK_SRC_WMASK = 16'h0fff;
  localparam logic [15:0] MASK_GATE_WMASK = 16'hbfff;
  localparam logic [15:0] FILTER_WMASK = 16'h007f;
  localparam logic [15:0] VREF_WMASK = 16'h07ef;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // ==========================================================
  // Field positions
  localparam int SRC_A_LSB = 0;
  localparam int SRC_B_LSB = 4;
  localparam int SRC_C_LSB = 8;
  localparam int GATE_AND_INV_A = 0;
  localparam int GATE_AND_TRUE_A = 1;
  localparam int GATE_AND_INV_B = 2;
  localparam int GATE_AND_TRUE_B = 3;
  localparam int GATE_AND_INV_C = 4;
  localparam int GATE_AND_TRUE_C = 5;
  localparam int GATE_AND_POS = 6;
  localparam int GATE_AND_NEG = 7;
  localparam int GATE_OR_INV_A = 8;
  localparam int GATE_OR_TRUE_A = 9;
  localparam int GATE_OR_INV_B = 10;
  localparam int GATE_OR_TRUE_B = 11;
  localparam int GATE_OR_INV_C = 12;
  localparam int GATE_OR_TRUE_C = 13;
  localparam int GATE_POLARITY = 15;
  localparam int FLT_DIV_LSB = 0;
  localparam int FLT_ON = 3;
  localparam int FLT_SRC_LSB = 4;
  localparam int VREF_STEP_LSB = 0;
  localparam int VREF_RANGE = 5;
  localparam int VREF_OUT_EN = 6;
  localparam int VREF_EN = 7;
  localparam int VREF_BG_LSB = 8;
  localparam int VREF_SEL = 10;

  // ==========================================================
  // Encodings
  localparam int PWM_OUTS = 6;
  localparam logic [3:0] SRC_LAST = 4'h5;
  localparam logic [2:0] FCLK_CY = 3'h0;
  localparam logic [2:0] FCLK_OSC = 3'h1;
  localparam logic [2:0] FCLK_PWM_EVT = 3'h2;
  localparam logic [2:0] FCLK_TMR2 = 3'h4;
  localparam logic [2:0] FCLK_TMR3 = 3'h5;
  localparam logic [1:0] BG_EXT_PIN = 2'h3;
  localparam logic [1:0] BG_NOMINAL = 2'h2;
  localparam logic [4:0] STEP_DIVISOR = 5'h18;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Filter clock source inputs, one bit each
  typedef struct packed {
    logic tmr3;
    logic tmr2;
    logic pwm_evt;
    logic osc;
    logic cy;
  } fclk_src_s;

  // Reference control presented to the analog side
  typedef struct packed {
    logic enable;
    logic ext_select;
    logic [1:0] bg_source;
    logic range;
    logic [3:0] step;
  } vref_ctrl_s;

endpackage

/* File: rtl/mask_gate.sv */
// Purpose: Mask selection and AND/OR gate array for comparator blanking
// Assumes: PWM outputs synchronous to hclk
// Notes: Combinational; top registers the result
`timescale 1ns/1ps
module mask_gate
  import cmp_mask_pkg::*;
(
  input wire logic [PWM_OUTS-1:0] pwm_out, // PWM outputs L1,H1,L2,H2,L3,H3
  input wire logic [11:0] src_sel, // Three 4-bit source selectors
  input wire logic [15:0] gate_ctrl, // Gating control bits
  output logic mask_active // Combined blanking mask
);

  logic [2:0] mask_in;
  logic [5:0] and_term;
  logic [5:0] or_term;
  logic and_out;
  logic or_in;

  // ==========================================================
  // Per-mask source selectors
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_sel
      wire [3:0] code = src_sel[4*g +: 4];
      // Reserved codes give a low mask
      assign mask_in[g] = (code <= SRC_LAST) ? pwm_out[code[2:0]] : 1'b0; // R1 R11
    end
  endgenerate

  // ==========================================================
  // AND gate: a disabled term reads one
  assign and_term[0] = gate_ctrl[GATE_AND_INV_A] ? ~mask_in[0] : 1'b1; // R4
  assign and_term[1] = gate_ctrl[GATE_AND_TRUE_A] ? mask_in[0] : 1'b1; // R3
  assign and_term[2] = gate_ctrl[GATE_AND_INV_B] ? ~mask_in[1] : 1'b1; // R5
  assign and_term[3] = gate_ctrl[GATE_AND_TRUE_B] ? mask_in[1] : 1'b1;
  assign and_term[4] = gate_ctrl[GATE_AND_INV_C] ? ~mask_in[2] : 1'b1;
  assign and_term[5] = gate_ctrl[GATE_AND_TRUE_C] ? mask_in[2] : 1'b1;
  // No enabled term gives a low AND output
  assign and_out = (|gate_ctrl[GATE_AND_TRUE_C:GATE_AND_INV_A]) & (&and_term);

  // ==========================================================
  // OR gate: a disabled term reads zero
  assign or_term[0] = gate_ctrl[GATE_OR_INV_A] & ~mask_in[0];
  assign or_term[1] = gate_ctrl[GATE_OR_TRUE_A] & mask_in[0];
  assign or_term[2] = gate_ctrl[GATE_OR_INV_B] & ~mask_in[1];
  assign or_term[3] = gate_ctrl[GATE_OR_TRUE_B] & mask_in[1];
  assign or_term[4] = gate_ctrl[GATE_OR_INV_C] & ~mask_in[2];
  assign or_term[5] = gate_ctrl[GATE_OR_TRUE_C] & mask_in[2];
  assign or_in = (gate_ctrl[GATE_AND_POS] & and_out) | (gate_ctrl[GATE_AND_NEG] & ~and_out);
  assign mask_active = (|or_term) | or_in;

endmodule

/* File: rtl/filter_clk_gen.sv */
// Purpose: Filter sample clock selection and power-of-two divide
// Assumes: Source clocks are synchronous level inputs
// Notes: Produces a one-cycle sample tick per divided rising edge
`timescale 1ns/1ps
module filter_clk_gen
  import cmp_mask_pkg::*;
#(
  parameter int DIV_W = 7
)
(
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  input wire fclk_src_s src, // Candidate sample clocks
  input wire logic [2:0] src_sel, // Source select code
  input wire logic [2:0] div_sel, // Divide exponent
  output logic tick // Sample tick, one cycle
);

  logic sel_clk;
  logic last_reg;
  logic edge_w;
  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] cnt_next;
  logic [DIV_W:0] div_mask;
  logic wrap;

  // ==========================================================
  // Source multiplexer; reserved codes stop the clock
  always_comb
  begin
    case (src_sel) // R6
      FCLK_CY: sel_clk = src.cy;
      FCLK_OSC: sel_clk = src.osc;
      FCLK_PWM_EVT: sel_clk = src.pwm_evt;
      FCLK_TMR2: sel_clk = src.tmr2;
      FCLK_TMR3: sel_clk = src.tmr3;
      default: sel_clk = 1'b0;
    endcase
  end

  // Divider wraps after 2**div_sel edges
  // At or above the end count wraps at once, so a smaller divide never stalls
  assign edge_w = sel_clk & ~last_reg;
  assign div_mask = (DIV_W+1)'(1) << div_sel;
  assign wrap = ({1'b0, cnt_reg} >= div_mask - (DIV_W+1)'(1)); // R7
  assign cnt_next = wrap ? '0 : cnt_reg + DIV_W'(1);
  assign tick = edge_w & wrap;

  // Edge register and divide counter
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      last_reg <= 1'b0;
      cnt_reg <= '0;
    end
    else
    begin
      last_reg <= sel_clk;
      if (edge_w)
        cnt_reg <= cnt_next;
    end
  end

endmodule

/* File: tb/cmp_mask_filter_ctrl_assertions.sv */
// Purpose: Port-level checks for the comparator mask/filter control block
// Assumes: Zero-wait slave, registers update in the write data phase
// Notes: Bound to every instance of the top module
`timescale 1ns/1ps
module cmp_mask_filter_ctrl_assertions
  import cmp_mask_pkg::*;
#(
  parameter int FILTER_DEPTH = 3
)
(
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset, active low
  input wire logic hsel, // Select
  input wire logic [7:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic [2:0] hsize, // Size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Ready in
  input wire logic [31:0] hrdata, // Read data
  input wire logic hreadyout, // Ready out
  input wire logic hresp, // Response
  input wire logic pin_direction_ctrl, // Pin direction
  input wire logic cmp_out, // Comparator output
  input wire logic mask_active_out, // Blanking mask
  input wire vref_ctrl_s vref_ctrl, // Reference control
  input wire logic bg_reserved, // Reserved code flag
  input wire logic ref_pin_oe // Pin drive enable
);
  // ========
  // Decoded transfers
  wire taken = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;
  wire wr_vref = taken && hwrite && haddr == OFS_VREF;
  wire rd_any = taken && !hwrite;
  wire vref_ctrl_s vref_wd = {hwdata[VREF_EN], hwdata[VREF_SEL], hwdata[9:8],
    hwdata[VREF_RANGE], hwdata[3:0]};

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ========
  // Assertions
  ready_always_a: assert property (hreadyout)
    else $error("hreadyout low");
  resp_okay_a: assert property (!hresp)
    else $error("hresp not OKAY");
  oe_dir_a: assert property (!pin_direction_ctrl |=> ref_pin_oe)
    else $error("ref pin not driven for output direction");
  oe_write_a: assert property (wr_vref ##1 hwdata[VREF_OUT_EN] |-> ##2 ref_pin_oe)
    else $error("ref pin not driven after enable write");
  vref_write_a: assert property (wr_vref |-> ##3 vref_ctrl == $past(vref_wd, 2))
    else $error("reference control does not follow write");
  bg_flag_a: assert property ($past(hresetn) |-> bg_reserved == !vref_ctrl.bg_source[1])
    else $error("reserved band gap flag wrong");
  unmapped_read_a: assert property (rd_any && haddr > OFS_STATUS |=> hrdata == 32'h00000000)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (rd_any |=> hrdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");

  // Main scenarios reached
  cover property (wr_vref);
  cover property (rd_any && haddr > OFS_STATUS);
  cover property ($rose(mask_active_out));
  cover property ($fell(cmp_out));
endmodule

bind cmp_mask_filter_ctrl cmp_mask_filter_ctrl_assertions #(.FILTER_DEPTH(FILTER_DEPTH)) u_chk (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
  .hreadyout, .hresp, .pin_direction_ctrl, .cmp_out, .mask_active_out, .vref_ctrl,
  .bg_reserved, .ref_pin_oe
);

/* File: tb/test_cmp_mask_filter_ctrl.sv */
// Purpose: Directed register and datapath tests for the mask/filter block
// Assumes: Zero-wait AHB-Lite slave, single word transfers
// Notes: Filter sample clocks are pumped by hand, four cycles a period
`timescale 1ns/1ps
module test_cmp_mask_filter_ctrl
  import cmp_mask_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [PWM_OUTS-1:0] pwm_out = '0;
  fclk_src_s fclk_src = '0;
  logic cmp_raw = 1'b0;
  logic pin_direction_ctrl = 1'b1;
  logic cmp_out;
  logic mask_active_out;
  logic bg_reserved;
  logic ref_pin_oe;
  vref_ctrl_s vref_ctrl;
  logic [31:0] rd;
  logic [7:0] ofs [4] = '{OFS_MASK_SRC, OFS_MASK_GATE, OFS_FILTER, OFS_VREF};
  logic [15:0] wm [4] = '{MASK_SRC_WMASK, MASK_GATE_WMASK, FILTER_WMASK, VREF_WMASK};
  logic [2:0] fsel [5] = '{FCLK_CY, FCLK_OSC, FCLK_PWM_EVT, FCLK_TMR2, FCLK_TMR3};
  logic [2:0] fdiv [5] = '{3'h0, 3'h7, 3'h1, 3'h2, 3'h6};
  int n;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;

  // 50 MHz clock
  always #10 hclk = ~hclk;

  cmp_mask_filter_ctrl #(.FILTER_DEPTH(3)) u_cmp_mask_filter_ctrl (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pwm_out, .fclk_src, .cmp_raw,
    .pin_direction_ctrl, .cmp_out, .mask_active_out, .vref_ctrl, .bg_reserved, .ref_pin_oe
  );

  // ========
  // Tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One single transfer; read data lands in rd
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Gate and source setup, then mask and blanked output
  task automatic mcase(input logic [15:0] g, input logic [15:0] s, input logic [5:0] p,
    input logic raw, input logic m);
    logic c;
    c = g[GATE_POLARITY] ? raw | m : raw & ~m;
    xfer(OFS_MASK_GATE, 1'b1, {16'h0000, g});
    xfer(OFS_MASK_SRC, 1'b1, {16'h0000, s});
    pwm_out <= p;
    cmp_raw <= raw;
    repeat (4) @(posedge hclk);
    chk("mask", {31'h0, m}, {31'h0, mask_active_out});
    chk("cmp_out", {31'h0, c}, {31'h0, cmp_out});
    // Status word mirrors filter, mask and output; filter idle here
    xfer(OFS_STATUS, 1'b0, 32'h0);
    chk("status", {29'h0, 1'b0, m, c}, rd);
  endtask

  // Reference write, then control, pin enable and reserved flag
  task automatic vcase(input logic [31:0] d, input logic pd, input logic [10:0] e);
    pin_direction_ctrl <= pd;
    xfer(OFS_VREF, 1'b1, d);
    repeat (3) @(posedge hclk);
    chk("vref", {21'h0, e}, {21'h0, bg_reserved, ref_pin_oe, vref_ctrl});
  endtask

  task automatic pump(input logic [4:0] m, input int cnt);
    repeat (cnt)
    begin
      fclk_src <= fclk_src_s'(m);
      repeat (2) @(posedge hclk);
      fclk_src <= '0;
      repeat (2) @(posedge hclk);
    end
  endtask

  task automatic summarize();
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      n_errors++;
      summarize();
    end
  end

  // ========
  // Main sequence
  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    // Flag is launched at the first edge after release, read one edge later
    @(posedge hclk);
    @(posedge hclk);
    chk("bg_reserved", 32'h1, {31'h0, bg_reserved});
    for (int k = 0; k < 4; k++)
    begin
      xfer(ofs[k], 1'b0, 32'h0);
      chk("reset", 32'h0, rd);
      xfer(ofs[k], 1'b1, 32'hffffffff);
      xfer(ofs[k], 1'b0, 32'h0);
      chk("wmask", {16'h0, wm[k]}, rd);
      xfer(ofs[k], 1'b1, 32'h0);
    end
    hsize <= 3'h1;
    xfer(OFS_MASK_SRC, 1'b1, 32'h00000005);
    hsize <= HSIZE_WORD;
    xfer(OFS_MASK_SRC, 1'b0, 32'h0);
    chk("halfword", 32'h0, rd);
    xfer(8'h20, 1'b1, 32'hffffffff);
    xfer(8'h20, 1'b0, 32'h0);
    chk("unmapped", 32'h0, rd);
    for (int k = 0; k < PWM_OUTS; k++)
    begin
      mcase(16'h0042, 16'(k), 6'(1 << k), 1'b1, 1'b1);
      mcase(16'h0042, 16'(k), ~6'(1 << k), 1'b1, 1'b0);
      mcase(16'h0041, 16'(k), 6'(1 << k), 1'b1, 1'b0);
      mcase(16'h0044, 16'(k) << 4, ~6'(1 << k), 1'b1, 1'b1);
      mcase(16'h0060, 16'(k) << 8, 6'(1 << k), 1'b1, 1'b1);
      mcase(16'h8042, 16'(k), 6'(1 << k), 1'b0, 1'b1);
    end
    mcase(16'h0042, 16'h0006, 6'h3f, 1'b1, 1'b0);
    vcase(32'h000007ef, 1'b1, 11'h3ff);
    vcase(32'h0000022f, 1'b1, 11'h05f);
    vcase(32'h00000140, 1'b1, 11'h620);
    vcase(32'h0000042f, 1'b0, 11'h69f);
    xfer(OFS_MASK_GATE, 1'b1, 32'h0);
    for (int k = 0; k < 5; k++)
    begin
      n = 1 << fdiv[k];
      xfer(OFS_FILTER, 1'b1, {25'h0, fsel[k], 1'b1, fdiv[k]});
      cmp_raw <= k[0];
      pump(5'(1 << k), 3 * n + 2);
      repeat (4) @(posedge hclk);
      chk("settled", {31'h0, k[0]}, {31'h0, cmp_out});
      cmp_raw <= ~k[0];
      pump(~5'(1 << k), 3 * n);
      chk("other clocks", {31'h0, k[0]}, {31'h0, cmp_out});
      pump(5'(1 << k), 2 * n);
      chk("early", {31'h0, k[0]}, {31'h0, cmp_out});
      pump(5'(1 << k), n);
      repeat (4) @(posedge hclk);
      chk("filtered", {31'h0, ~k[0]}, {31'h0, cmp_out});
    end
    summarize();
  end
endmodule
